// file: core/sti_dev.sv
`timescale 1ns/10ps
`include "sti_map.svh"
module sti_dev #(
  parameter int PWR_UP_CYC = `STI_PWR_UP_US * `STI_REF_MHZ
) (
  // bus pins
  sti_bus_if.dev           bus,
  // clocks and reset
  input  wire logic        ref_clk,
  input  wire logic        link_clk,
  input  wire logic        reset_n,
  // measurement side
  input  wire logic        alert_cond,
  input  wire logic        meas_busy,
  input  wire logic        rd_valid,
  input  wire logic [15:0] rd_word0,
  input  wire logic [15:0] rd_word1,
  output logic             rd_taken,
  // command side
  output logic             cmd_stb,
  output logic [15:0]      cmd_word,
  output logic             cmd_has_data,
  output logic [15:0]      cmd_data,
  // status
  output logic             ready,
  output logic             idle
);
  localparam logic [7:0]  RST_CYC = 8'(`STI_RST_CYC);
  localparam logic [17:0] PU_LAST = 18'(PWR_UP_CYC - 1);

  sti_pkg::sti_ref_t r_q, r_d;
  sti_pkg::sti_lnk_t l_q, l_d;
  logic              lrst1_q, lrst_n_q;

  function automatic logic [7:0] tx_byte(input logic [2:0]  k,
                                         input logic [15:0] w0,
                                         input logic [15:0] w1);
    case (k)
      3'h0:    tx_byte = w0[15:8];
      3'h1:    tx_byte = w0[7:0];
      3'h2:    tx_byte = sti_pkg::crc8(w0);
      3'h3:    tx_byte = w1[15:8];
      3'h4:    tx_byte = w1[7:0];
      default: tx_byte = sti_pkg::crc8(w1);
    endcase
  endfunction

  // ****************************************
  // reference clock side
  // ****************************************
  always_comb begin
    r_d         = r_q;
    r_d.hr1     = bus.hard_reset_low_in;
    r_d.hr2     = r_q.hr1;
    if (r_q.hr2)
      r_d.lowc = 8'h00;
    else if (r_q.lowc != RST_CYC)
      r_d.lowc = r_q.lowc + 8'h01;
    r_d.hrst    = !r_q.hr2 && (r_q.lowc == RST_CYC);   // [R10]
    if (r_q.hrst) begin
      r_d.puc = 18'h0_0000;
      r_d.pwr = 1'b0;
    end else if (!r_q.pwr) begin
      r_d.puc = r_q.puc + 18'h0_0001;
      r_d.pwr = (r_q.puc == PU_LAST);                   // [R16]
    end
    r_d.ev1     = l_q.ev_tgl;
    r_d.ev2     = r_q.ev1;
    r_d.ev3     = r_q.ev2;
    r_d.dn1     = l_q.done_tgl;
    r_d.dn2     = r_q.dn1;
    r_d.dn3     = r_q.dn2;
    r_d.bz1     = (l_q.st != sti_pkg::L_IDLE);
    r_d.bz2     = r_q.bz1;
    r_d.taken   = r_q.dn2 ^ r_q.dn3;
    r_d.cmd_stb = (r_q.ev2 ^ r_q.ev3) && r_q.pwr;
    if (r_q.ev2 ^ r_q.ev3) begin
      // payload stays put until the next toggle, a command gap away
      r_d.cmd  = l_q.ev_cmd;
      r_d.hasd = l_q.ev_hasd;
      r_d.dat  = l_q.ev_dat;
    end
    r_d.alert   = alert_cond && r_q.pwr;                // [R9]
    r_d.idle    = r_q.pwr && !r_q.bz2 && !meas_busy;    // [R18]
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n)
      r_q <= '0;
    else
      r_q <= r_d;
  end

  assign rd_taken     = r_q.taken;
  assign cmd_stb      = r_q.cmd_stb;
  assign cmd_word     = r_q.cmd;
  assign cmd_has_data = r_q.hasd;
  assign cmd_data     = r_q.dat;
  assign ready        = r_q.pwr;
  assign idle         = r_q.idle;
  assign bus.alert    = r_q.alert;

  // ****************************************
  // link side
  // ****************************************
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      lrst1_q  <= 1'b0;
      lrst_n_q <= 1'b0;
    end else begin
      lrst1_q  <= 1'b1;
      lrst_n_q <= lrst1_q;
    end
  end

  always_comb begin
    logic sr, sf, sa, so, hit;
    logic [6:0] me;
    sr  = l_q.sy2[1] && !l_q.sy3[1];
    sf  = !l_q.sy2[1] && l_q.sy3[1];
    sa  = l_q.sy2[1] && l_q.sy3[1] && !l_q.sy2[0] && l_q.sy3[0];
    so  = l_q.sy2[1] && l_q.sy3[1] && l_q.sy2[0] && !l_q.sy3[0];
    me  = l_q.adr ? `STI_ADDR_HI : `STI_ADDR_LO;        // [R5]
    hit = (l_q.sh[7:1] == me) && l_q.rd2;               // [R8] [R16]
    l_d     = l_q;
    // no timeout anywhere, so the clock may stop for any time
    l_d.sy1 = {bus.scl, bus.sda};                       // [R1] [R2]
    l_d.sy2 = l_q.sy1;
    l_d.sy3 = l_q.sy2;
    l_d.ad1 = bus.addr_pin;
    l_d.ad2 = l_q.ad1;
    l_d.rd1 = r_q.pwr;
    l_d.rd2 = l_q.rd1;
    l_d.rv1 = rd_valid;
    l_d.rv2 = l_q.rv1;
    if (!l_q.rd2) begin
      l_d.st     = sti_pkg::L_IDLE;
      l_d.sda_oe = 1'b0;
      l_d.scl_oe = 1'b0;
    end else if (so) begin                              // [R17]
      if (l_q.st == sti_pkg::L_RXB && l_q.cnt == 4'h1) begin
        // bad crc or unknown length leaves state alone
        if (sti_pkg::cmd_ok(l_q.rxb[15:0]) && l_q.nb == 3'h2) begin
          l_d.ev_tgl  = !l_q.ev_tgl;                    // [R12] [R19]
          l_d.ev_cmd  = l_q.rxb[15:0];
          l_d.ev_hasd = 1'b0;
          l_d.strch   = l_q.rxb[`STI_STRETCH_BIT];      // [R4]
        end else if (l_q.nb == 3'h5 && sti_pkg::cmd_ok(l_q.rxb[39:24])
                     && sti_pkg::crc8(l_q.rxb[23:8]) == l_q.rxb[7:0]) begin
          l_d.ev_tgl  = !l_q.ev_tgl;                    // [R13] [R14]
          l_d.ev_cmd  = l_q.rxb[39:24];
          l_d.ev_dat  = l_q.rxb[23:8];
          l_d.ev_hasd = 1'b1;
        end
      end
      l_d.st     = sti_pkg::L_IDLE;
      l_d.sda_oe = 1'b0;
    end else if (sa) begin                              // [R17]
      l_d.st     = sti_pkg::L_ADR;
      l_d.cnt    = 4'h0;
      l_d.nb     = 3'h0;
      l_d.adr    = l_q.ad2;                             // [R6]
      l_d.sda_oe = 1'b0;
    end else begin
      case (l_q.st)
        sti_pkg::L_ADR, sti_pkg::L_RXB: begin
          if (sr) begin
            l_d.sh  = {l_q.sh[6:0], l_q.sy2[0]};
            l_d.cnt = l_q.cnt + 4'h1;
          end else if (sf && l_q.cnt == 4'h8) begin
            l_d.cnt = 4'h0;
            if (l_q.st == sti_pkg::L_ADR) begin
              l_d.rw = l_q.sh[0];
              // without data and without stretching a read is refused
              if (hit && (!l_q.sh[0] || l_q.rv2 || l_q.strch)) begin
                l_d.st     = sti_pkg::L_ACK;
                l_d.sda_oe = 1'b1;                      // [R3]
              end else begin
                l_d.st = sti_pkg::L_IDLE;
              end
            end else if (l_q.nb != 3'h5) begin
              l_d.rxb    = {l_q.rxb[31:0], l_q.sh};
              l_d.nb     = l_q.nb + 3'h1;
              l_d.st     = sti_pkg::L_ACK;
              l_d.sda_oe = 1'b1;
            end else begin
              l_d.st = sti_pkg::L_IDLE;
            end
          end
        end
        sti_pkg::L_ACK: begin
          if (sf) begin
            l_d.sda_oe = 1'b0;
            l_d.idx    = 3'h0;
            if (!l_q.rw) begin
              l_d.st = sti_pkg::L_RXB;
            end else if (l_q.rv2) begin
              l_d.sh     = tx_byte(3'h0, rd_word0, rd_word1);
              l_d.sda_oe = !l_d.sh[7];
              l_d.st     = sti_pkg::L_TXB;
            end else begin
              l_d.scl_oe = 1'b1;                        // [R4]
              l_d.st     = sti_pkg::L_HOLD;
            end
          end
        end
        sti_pkg::L_HOLD: begin
          if (l_q.rv2) begin
            // data settles a cycle before the clock is let go
            l_d.sh     = tx_byte(3'h0, rd_word0, rd_word1);
            l_d.sda_oe = !l_d.sh[7];
            l_d.st     = sti_pkg::L_TXB;
          end
        end
        sti_pkg::L_TXB: begin
          l_d.scl_oe = 1'b0;                            // [R4]
          if (sf) begin
            l_d.cnt = l_q.cnt + 4'h1;
            if (l_q.cnt == 4'h7) begin
              l_d.sda_oe = 1'b0;
              l_d.st     = sti_pkg::L_TAK;
            end else begin
              l_d.sh     = {l_q.sh[6:0], 1'b0};
              l_d.sda_oe = !l_q.sh[6];
            end
          end
        end
        sti_pkg::L_TAK: begin
          if (sr)
            l_d.mack = !l_q.sy2[0];
          if (sf) begin
            l_d.cnt = 4'h0;
            if (l_q.mack && l_q.idx != 3'h5) begin      // [R13]
              l_d.idx    = l_q.idx + 3'h1;
              l_d.sh     = tx_byte(l_d.idx, rd_word0, rd_word1);
              l_d.sda_oe = !l_d.sh[7];
              l_d.st     = sti_pkg::L_TXB;
            end else begin
              l_d.done_tgl = !l_q.done_tgl;
              l_d.st       = sti_pkg::L_IDLE;
            end
          end
        end
        default: l_d.st = sti_pkg::L_IDLE;
      endcase
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n_q) begin
    if (!lrst_n_q)
      l_q <= '0;
    else
      l_q <= l_d;
  end

  assign bus.scl_d_o  = 1'b0;                           // [R3]
  assign bus.sda_d_o  = 1'b0;
  assign bus.scl_d_oe = l_q.scl_oe;
  assign bus.sda_d_oe = l_q.sda_oe;
endmodule

// file: core/sti_map.svh
`ifndef STI_MAP_SVH
`define STI_MAP_SVH
// Contract
// [R1] target accepts any clock rate up to 1000 kHz
// [R2] at or below 400 kHz follow fast mode
// [R3] lines only pulled low, pull-ups raise them
// [R4] target stretches clock when the command asks
// [R5] address 0x44 for select low, 0x45 high
// [R6] address select re-read at every transaction
// [R7] address select held steady during transaction
// [R8] header: seven address bits, then read/write bit
// [R9] alert output high when alert condition holds; target keeps it low until ready
// [R10] reset pin low at least 1 us resets
// [R11] master waits 1 ms between commands; host waits only after a write and returns to idle at once after a read
// [R12] commands are 16-bit words with 3-bit CRC
// [R13] every 16-bit data word followed by CRC byte
// [R14] written data accepted only with correct CRC
// [R15] master may skip reading the CRC bytes
// [R16] commands accepted only after power-up time
// [R17] transactions framed by START and STOP
// [R18] idle entered by itself when nothing happens
// [R19] bad or unknown command word is ignored

// ****************************************
// bus addresses and checksums
// ****************************************
`define STI_ADDR_LO     7'h44
`define STI_ADDR_HI     7'h45
`define STI_CRC8_POLY   8'h31
`define STI_CRC8_INIT   8'hFF
`define STI_CRC3_POLY   3'h3
`define STI_STRETCH_BIT 11

// ****************************************
// timing
// ****************************************
`define STI_REF_MHZ      200
`define STI_RST_PULSE_NS 1000
`define STI_RST_CYC      ((`STI_RST_PULSE_NS * `STI_REF_MHZ + 999) / 1000)
`define STI_PWR_UP_US    1000
`define STI_CMD_GAP_US   1000
`define STI_SCL_KHZ      400
`define STI_QTR_CYC      ((`STI_REF_MHZ * 1000) / (`STI_SCL_KHZ * 4))
`endif

// file: core/sti_pkg.sv
`include "sti_map.svh"
package sti_pkg;
  typedef enum logic [2:0] {
    L_IDLE, L_ADR, L_RXB, L_ACK, L_HOLD, L_TXB, L_TAK
  } sti_lst_t;

  typedef enum logic [2:0] {
    H_IDLE, H_STA, H_BIT, H_STO, H_GAP, H_RST
  } sti_hst_st_t;

  typedef struct packed {
    logic        hr1, hr2, hrst, pwr, idle, alert;
    logic [7:0]  lowc;
    logic [17:0] puc;
    logic        ev1, ev2, ev3, dn1, dn2, dn3, bz1, bz2;
    logic        cmd_stb, taken, hasd;
    logic [15:0] cmd, dat;
  } sti_ref_t;

  typedef struct packed {
    logic [1:0]  sy1, sy2, sy3;
    logic        ad1, ad2, rd1, rd2, rv1, rv2;
    sti_lst_t    st;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic [39:0] rxb;
    logic [2:0]  nb, idx;
    logic        adr, rw, mack, strch, sda_oe, scl_oe;
    logic        ev_tgl, ev_hasd, done_tgl;
    logic [15:0] ev_cmd, ev_dat;
  } sti_lnk_t;

  typedef struct packed {
    sti_hst_st_t st;
    logic [17:0] tmr;
    logic [1:0]  ph;
    logic [3:0]  bn;
    logic [2:0]  byn, last;
    logic [7:0]  sh;
    logic [47:0] rx;
    logic [15:0] cmd, wd;
    logic        rd, nack, scl_oe, sda_oe, adr, rst, done, crc_ok;
    logic        s1, s2, d1, d2;
  } sti_hst_t;

  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = `STI_CRC8_INIT;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ `STI_CRC8_POLY)
                        : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  // low three bits of a command guard the upper thirteen
  function automatic logic cmd_ok(input logic [15:0] w);
    logic [2:0] c;
    c = 3'h0;
    for (int i = 15; i >= 3; i--) begin
      c = (c[2] ^ w[i]) ? ({c[1:0], 1'b0} ^ `STI_CRC3_POLY)
                        : {c[1:0], 1'b0};
    end
    return c == w[2:0];
  endfunction
endpackage

// file: core/sti_bus_if.sv
`timescale 1ns/10ps
interface sti_bus_if;
  logic scl_h_o, scl_h_oe, sda_h_o, sda_h_oe;
  logic scl_d_o, scl_d_oe, sda_d_o, sda_d_oe;
  logic scl, sda;
  logic addr_pin, hard_reset_low_in, alert;

  // pull-up wins unless someone drives low
  assign scl = ~((scl_h_oe & ~scl_h_o) | (scl_d_oe & ~scl_d_o));
  assign sda = ~((sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o));

  modport host (
    output scl_h_o, scl_h_oe, sda_h_o, sda_h_oe,
    output addr_pin, hard_reset_low_in,
    input  scl, sda, alert
  );
  modport dev (
    output scl_d_o, scl_d_oe, sda_d_o, sda_d_oe, alert,
    input  scl, sda, addr_pin, hard_reset_low_in
  );
endinterface

// file: core/sti_host.sv
`timescale 1ns/10ps
`include "sti_map.svh"
module sti_host #(
  parameter int GAP_CYC = `STI_CMD_GAP_US * `STI_REF_MHZ
) (
  // bus pins
  sti_bus_if.host          bus,
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // request
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic        req_read,
  input  wire logic        req_data,
  input  wire logic        req_target,
  input  wire logic [15:0] req_cmd,
  input  wire logic [15:0] req_wdata,
  input  wire logic        rst_req,
  // answer
  output logic             done,
  output logic             nack,
  output logic             crc_ok,
  output logic [15:0]      rd_word0,
  output logic [15:0]      rd_word1,
  output logic             alert_seen
);
  localparam logic [17:0] QTR = 18'(`STI_QTR_CYC);
  localparam logic [17:0] RST = 18'(`STI_RST_CYC);
  localparam logic [17:0] GAP = 18'(GAP_CYC);

  sti_pkg::sti_hst_t h_q, h_d;
  logic              al1_q, al2_q;

  always_comb begin
    logic rxr;
    rxr      = h_q.rd && (h_q.byn != 3'h0);
    h_d      = h_q;
    h_d.done = 1'b0;
    h_d.s1   = bus.scl;
    h_d.s2   = h_q.s1;
    h_d.d1   = bus.sda;
    h_d.d2   = h_q.d1;
    case (h_q.st)
      sti_pkg::H_IDLE: begin
        if (rst_req) begin
          h_d.st  = sti_pkg::H_RST;
          h_d.rst = 1'b1;
          h_d.tmr = RST;                                // [R10]
        end else if (req_valid) begin
          h_d.adr  = req_target;                        // [R7]
          h_d.rd   = req_read;
          h_d.cmd  = req_cmd;                           // [R12]
          h_d.wd   = req_wdata;
          h_d.last = req_read ? 3'h6 : (req_data ? 3'h5 : 3'h2);
          h_d.sh   = {req_target ? `STI_ADDR_HI : `STI_ADDR_LO,
                      req_read};                        // [R8]
          h_d.byn  = 3'h0;
          h_d.bn   = 4'h0;
          h_d.ph   = 2'h0;
          h_d.nack = 1'b0;
          h_d.tmr  = QTR;                               // [R2]
          h_d.st   = sti_pkg::H_STA;
        end
      end
      sti_pkg::H_RST, sti_pkg::H_GAP: begin
        if (h_q.tmr != 18'h0_0000) begin
          h_d.tmr = h_q.tmr - 18'h0_0001;               // [R11]
        end else begin
          h_d.rst = 1'b0;
          h_d.st  = sti_pkg::H_IDLE;
        end
      end
      default: begin
        if (h_q.tmr != 18'h0_0000) begin
          h_d.tmr = h_q.tmr - 18'h0_0001;
        end else if (h_q.ph == 2'h2 && !h_q.s2) begin
          // target still stretching the clock
          h_d.tmr = 18'h0_0000;
        end else begin
          h_d.tmr = QTR;
          h_d.ph  = h_q.ph + 2'h1;
          case ({h_q.st == sti_pkg::H_BIT, h_q.st == sti_pkg::H_STO,
                 h_q.ph})
            4'h0: h_d.sda_oe = 1'b1;                    // [R17]
            4'h1: begin
              h_d.scl_oe = 1'b1;
              h_d.ph     = 2'h0;
              h_d.st     = sti_pkg::H_BIT;
            end
            4'h8: h_d.sda_oe = (h_q.bn == 4'h8)
                             ? (rxr && h_q.byn != h_q.last)
                             : (!rxr && !h_q.sh[7]);
            4'h9: h_d.scl_oe = 1'b0;
            4'hA: begin
              if (h_q.bn != 4'h8)
                h_d.sh = {h_q.sh[6:0], h_q.d2};
              else if (!rxr)
                h_d.nack = h_q.d2;
            end
            4'hB: begin
              h_d.scl_oe = 1'b1;
              if (h_q.bn != 4'h8) begin
                h_d.bn = h_q.bn + 4'h1;
              end else begin
                h_d.bn = 4'h0;
                if (rxr)
                  h_d.rx = {h_q.rx[39:0], h_q.sh};
                if (h_q.nack || h_q.byn == h_q.last) begin
                  h_d.st = sti_pkg::H_STO;
                end else begin
                  h_d.byn = h_q.byn + 3'h1;
                  case (h_d.byn)
                    3'h1:    h_d.sh = h_q.cmd[15:8];
                    3'h2:    h_d.sh = h_q.cmd[7:0];
                    3'h3:    h_d.sh = h_q.wd[15:8];
                    3'h4:    h_d.sh = h_q.wd[7:0];
                    default: h_d.sh = sti_pkg::crc8(h_q.wd); // [R13] [R14]
                  endcase
                end
              end
            end
            4'h4: h_d.sda_oe = 1'b1;
            4'h5: h_d.scl_oe = 1'b0;
            4'h6: begin
              h_d.sda_oe = 1'b0;                        // [R17]
              h_d.done   = 1'b1;
              // checks both crc bytes; meaningless after a short read
              h_d.crc_ok = sti_pkg::crc8(h_q.rx[47:32]) == h_q.rx[31:24]
                        && sti_pkg::crc8(h_q.rx[23:8]) == h_q.rx[7:0]; // [R15]
              h_d.st     = h_q.rd ? sti_pkg::H_IDLE : sti_pkg::H_GAP;
              h_d.tmr    = h_q.rd ? 18'h0_0000 : GAP;   // [R11]
            end
            default: h_d.st = sti_pkg::H_IDLE;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      h_q   <= '0;
      al1_q <= 1'b0;
      al2_q <= 1'b0;
    end else begin
      h_q   <= h_d;
      al1_q <= bus.alert;
      al2_q <= al1_q;
    end
  end

  assign req_ready             = (h_q.st == sti_pkg::H_IDLE) && !rst_req;
  assign done                  = h_q.done;
  assign nack                  = h_q.nack;
  assign crc_ok                = h_q.crc_ok;
  assign rd_word0              = h_q.rx[47:32];
  assign rd_word1              = h_q.rx[23:8];
  assign alert_seen            = al2_q;
  assign bus.scl_h_o           = 1'b0;                  // [R3]
  assign bus.sda_h_o           = 1'b0;
  assign bus.scl_h_oe          = h_q.scl_oe;
  assign bus.sda_h_oe          = h_q.sda_oe;
  assign bus.addr_pin          = h_q.adr;
  assign bus.hard_reset_low_in = !h_q.rst;
endmodule

// file: verification/sti_checker.sv
`timescale 1ns/10ps
module sti_checker #(
  parameter int GAP = 40
) (
  // clocks and reset
  input wire logic ref_clk,
  input wire logic link_clk,
  input wire logic reset_n,
  // bus pins
  input wire logic scl_h_o,
  input wire logic scl_h_oe,
  input wire logic sda_h_o,
  input wire logic sda_h_oe,
  input wire logic scl_d_o,
  input wire logic scl_d_oe,
  input wire logic sda_d_o,
  input wire logic sda_d_oe,
  input wire logic scl,
  input wire logic sda,
  input wire logic addr_pin,
  input wire logic hard_reset_low_in
);
  // ****************************************
  // framing seen from the ref clock
  // ****************************************
  logic        scl_q, sda_q, xfer_q, start_w, stop_w, rise_w;
  logic [3:0]  bit_q;
  logic [6:0]  hdr_q;
  logic [15:0] low_q, gap_q;

  assign start_w = scl & scl_q & sda_q & ~sda;
  assign stop_w  = scl & scl_q & ~sda_q & sda;
  assign rise_w  = scl & ~scl_q;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      xfer_q <= 1'b0;
      bit_q  <= 4'h9;
      hdr_q  <= 7'h00;
      low_q  <= 16'h0000;
      gap_q  <= 16'hffff;
    end else begin
      scl_q  <= scl;
      sda_q  <= sda;
      xfer_q <= start_w | (xfer_q & ~stop_w);
      if (start_w) bit_q <= 4'h0;
      else if (rise_w && bit_q != 4'h9) bit_q <= bit_q + 4'h1;
      if (rise_w && bit_q < 4'h7) hdr_q <= {hdr_q[5:0], sda};
      // saturate so long quiet spells never wrap
      if (hard_reset_low_in) low_q <= 16'h0000;
      else if (low_q != 16'hffff) low_q <= low_q + 16'h0001;
      if (stop_w) gap_q <= 16'h0000;
      else if (gap_q != 16'hffff) gap_q <= gap_q + 16'h0001;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_pull_low_only: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    !((scl_h_oe & scl_h_o) | (sda_h_oe & sda_h_o) |
      (scl_d_oe & scl_d_o) | (sda_d_oe & sda_d_o)))
    else $error("bus line driven high");
  a_idle_scl_high: assert property (
    @(posedge ref_clk) disable iff (!reset_n) !xfer_q |-> scl)
    else $error("clock low outside a transfer");
  a_addr_steady: assert property (
    @(posedge ref_clk) disable iff (!reset_n) xfer_q |-> $stable(addr_pin))
    else $error("address select moved in a transfer");
  a_header_addr: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    rise_w && bit_q == 4'h7 |-> hdr_q == (addr_pin ? 7'h45 : 7'h44))
    else $error("header address wrong");
  a_header_ack: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    rise_w && bit_q == 4'h8 |-> !sda)
    else $error("header not acknowledged");
  a_reset_width: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    $rose(hard_reset_low_in) |-> low_q >= 16'h00c8)
    else $error("reset pulse too short");
  a_cmd_gap: assert property (
    @(posedge ref_clk) disable iff (!reset_n) start_w |-> gap_q > GAP)
    else $error("start too soon after stop");
  a_dev_sda_still: assert property (
    @(posedge link_clk) disable iff (!reset_n)
    $changed(sda_d_oe) |-> !scl)
    else $error("target moved data while clock high");

  c_start: cover property (
    @(posedge ref_clk) disable iff (!reset_n) start_w);
  c_stretch: cover property (
    @(posedge link_clk) disable iff (!reset_n) $rose(scl_d_oe));
  c_pin_reset: cover property (
    @(posedge ref_clk) disable iff (!reset_n) $rose(hard_reset_low_in));
endmodule

// file: verification/sensor_i2c_target_interface_tb.sv
`timescale 1ns/10ps
module sensor_i2c_target_interface_tb;
  // short counts keep the run near 90k cycles
  localparam int PWR   = 50;
  localparam int GAP   = 40;
  localparam int LIMIT = 99000;
  logic        ref_clk, link_clk, reset_n, held;
  logic        req_valid, req_read, req_data, req_target, rst_req;
  logic [15:0] req_cmd, req_wdata, dv_w0, dv_w1, cmd_word, cmd_data;
  logic [15:0] rd_word0, rd_word1;
  logic        req_ready, done, nack, crc_ok, alert_seen, ready, idle;
  logic        alert_cond, meas_busy, rd_valid, rd_taken, cmd_stb, cmd_has_data;
  int          n_fail = 0, comparisons = 0, cyc = 0, n_cmd = 0, n_taken = 0;

  sti_bus_if sti_bus_if_i ();
  sti_host #(.GAP_CYC(GAP)) sti_host_i (
    .bus(sti_bus_if_i), .ref_clk, .reset_n, .req_valid, .req_ready,
    .req_read, .req_data, .req_target, .req_cmd, .req_wdata, .rst_req,
    .done, .nack, .crc_ok, .rd_word0, .rd_word1, .alert_seen);
  sti_dev #(.PWR_UP_CYC(PWR)) sti_dev_i (
    .bus(sti_bus_if_i), .ref_clk, .link_clk, .reset_n, .alert_cond,
    .meas_busy, .rd_valid, .rd_word0(dv_w0), .rd_word1(dv_w1), .rd_taken,
    .cmd_stb, .cmd_word, .cmd_has_data, .cmd_data, .ready, .idle);
  sti_checker #(.GAP(GAP)) sti_checker_i (
    .ref_clk, .link_clk, .reset_n,
    .scl_h_o(sti_bus_if_i.scl_h_o), .scl_h_oe(sti_bus_if_i.scl_h_oe),
    .sda_h_o(sti_bus_if_i.sda_h_o), .sda_h_oe(sti_bus_if_i.sda_h_oe),
    .scl_d_o(sti_bus_if_i.scl_d_o), .scl_d_oe(sti_bus_if_i.scl_d_oe),
    .sda_d_o(sti_bus_if_i.sda_d_o), .sda_d_oe(sti_bus_if_i.sda_d_oe),
    .scl(sti_bus_if_i.scl), .sda(sti_bus_if_i.sda),
    .addr_pin(sti_bus_if_i.addr_pin),
    .hard_reset_low_in(sti_bus_if_i.hard_reset_low_in));

  // ****************************************
  // clocks, monitors, helpers
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7.3;
    forever #15 link_clk = ~link_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cmd_stb === 1'b1) n_cmd <= n_cmd + 1;
    if (rd_taken === 1'b1) n_taken <= n_taken + 1;
    if (cyc == LIMIT) begin
      n_fail = n_fail + 1;
      close_out;
    end
  end
  function automatic logic [15:0] mk_cmd(input logic [12:0] hi);
    logic [2:0] c;
    c = 3'h0;
    for (int i = 12; i >= 0; i--)
      c = {c[1:0], 1'b0} ^ ((c[2] ^ hi[i]) ? 3'h3 : 3'h0);
    return {hi, c};
  endfunction
  task automatic chk1(input string what, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %b got %b", what, e, g);
    end
  endtask
  task automatic chk16(input string what, input logic [15:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask
  task automatic xfer(input logic rd, dt, tg, input logic [15:0] c, w);
    req_read   <= rd;
    req_data   <= dt;
    req_target <= tg;
    req_cmd    <= c;
    req_wdata  <= w;
    req_valid  <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 60000 && req_ready !== 1'b1; i++) @(posedge ref_clk);
    req_valid <= 1'b0;
    for (int i = 0; i < 60000 && done !== 1'b1; i++) @(posedge ref_clk);
    chk1("done", 1'b1, done);
  endtask
  task automatic wait_cmd(input int n);
    for (int i = 0; i < 200 && n_cmd != n; i++) @(posedge ref_clk);
    chk1("cmd_stb", 1'b1, n_cmd == n);
  endtask
  task close_out;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_power;
    int i;
    chk1("ready", 1'b0, ready);
    for (i = 0; i < PWR + 40 && ready !== 1'b1; i++) @(posedge ref_clk);
    chk1("early", 1'b1, i >= PWR - 5);
    repeat (2) @(posedge ref_clk);
    chk1("idle", 1'b1, idle);
    meas_busy <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk1("idle", 1'b0, idle);
    meas_busy <= 1'b0;
  endtask
  task automatic t_cmds;
    logic [15:0] c;
    // bit 11 set: turns stretching on for the read
    c = mk_cmd(13'h0580);
    xfer(1'b0, 1'b0, 1'b0, c, 16'h0000);
    repeat (GAP / 2) @(posedge ref_clk);
    chk1("gap", 1'b0, req_ready);
    chk1("nack", 1'b0, nack);
    wait_cmd(1);
    chk16("cmd", c, cmd_word);
    chk1("has_data", 1'b0, cmd_has_data);
    xfer(1'b0, 1'b0, 1'b1, mk_cmd(13'h0123) ^ 16'h0001, 16'h0000);
    chk1("nack", 1'b0, nack);
    repeat (200) @(posedge ref_clk);
    chk1("ignored", 1'b1, n_cmd == 1);
    c = mk_cmd(13'h1a2b);
    xfer(1'b0, 1'b1, 1'b0, c, 16'h55aa);
    chk1("nack", 1'b0, nack);
    wait_cmd(2);
    chk1("has_data", 1'b1, cmd_has_data);
    chk16("data", 16'h55aa, cmd_data);
  endtask
  task automatic t_read;
    dv_w0 <= 16'hbeef;
    dv_w1 <= 16'h1234;
    fork
      xfer(1'b1, 1'b0, 1'b0, 16'h0000, 16'h0000);
      begin
        for (int i = 0; i < 20000 && sti_bus_if_i.scl_d_oe !== 1'b1; i++)
          @(posedge ref_clk);
        held = sti_bus_if_i.scl_d_oe;
        repeat (600) @(posedge ref_clk);
        rd_valid <= 1'b1;
      end
    join
    chk1("stretch", 1'b1, held);
    chk16("word0", 16'hbeef, rd_word0);
    chk16("word1", 16'h1234, rd_word1);
    chk1("crc_ok", 1'b1, crc_ok);
    for (int i = 0; i < 200 && n_taken != 1; i++) @(posedge ref_clk);
    chk1("taken", 1'b1, n_taken == 1);
    rd_valid <= 1'b0;
  endtask
  task automatic t_alert_reset;
    alert_cond <= 1'b1;
    for (int i = 0; i < 10 && alert_seen !== 1'b1; i++) @(posedge ref_clk);
    chk1("alert", 1'b1, sti_bus_if_i.alert);
    chk1("alert_seen", 1'b1, alert_seen);
    alert_cond <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk1("alert_seen", 1'b0, alert_seen);
    rst_req <= 1'b1;
    @(posedge ref_clk);
    rst_req <= 1'b0;
    for (int i = 0; i < 2000 && ready !== 1'b0; i++) @(posedge ref_clk);
    chk1("ready", 1'b0, ready);
    for (int i = 0; i < 2000 && ready !== 1'b1; i++) @(posedge ref_clk);
    chk1("ready", 1'b1, ready);
  endtask

  initial begin
    {req_valid, req_read, req_data, req_target, rst_req} = 5'h00;
    {alert_cond, meas_busy, rd_valid} = 3'h0;
    {req_cmd, req_wdata, dv_w0, dv_w1} = '0;
    reset_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_power;
    t_cmds;
    t_read;
    t_alert_reset;
    close_out;
  end
endmodule
